// ---- hdl/clhw_pkg.sv ----
// Shared constants, types and state records of the classifier lock and header walk block
package clhw_pkg;

  // ***********************************************************
  // Sizes
  // ***********************************************************
  localparam int LOCKS    = 4;
  localparam int LIDX_W   = 2;
  localparam int LAYERS   = 3;
  localparam int OFF_W    = 16;
  localparam int PROT_W   = 16;
  localparam int PORT_W   = 8;
  localparam int HANDLE_W = 32;
  localparam int DATA_W   = 32;
  localparam int RES_W    = 8;

  // ***********************************************************
  // Values and field positions
  // ***********************************************************
  localparam logic [PROT_W-1:0] PROT_UNKNOWN  = 16'hFFFF;
  localparam logic [OFF_W-1:0]  ALIGN_MASK    = 16'hFFFC;
  localparam logic [RES_W-1:0]  RESET_RESULT  = 8'hFF;
  localparam logic [RES_W-1:0]  RESET_STATUS  = 8'h00;
  localparam int                NXT_PROT_LSB  = 0;
  localparam int                HDR_LEN_LSB   = 16;
  localparam int                HDR_LEN_W     = 8;
  localparam logic [1:0]        L3_IDX        = 2'h0;
  localparam logic [1:0]        L4_IDX        = 2'h1;
  localparam logic [1:0]        L7_IDX        = 2'h2;
  localparam logic [PROT_W-1:0] L3_PROT_V4    = 16'h0800;
  localparam logic [PROT_W-1:0] L3_PROT_V6    = 16'h86DD;
  localparam logic [PROT_W-1:0] L4_PROT_TCP   = 16'h0006;
  localparam logic [PROT_W-1:0] L4_PROT_UDP   = 16'h0011;
  localparam logic [PROT_W-1:0] L7_PROT_WEB   = 16'h0050;
  localparam logic [PROT_W-1:0] L7_PROT_NAME  = 16'h0035;

  // ***********************************************************
  // Types
  // ***********************************************************
  typedef enum logic [1:0] {W_IDLE, W_SELECT, W_FETCH} clhw_walk_t;

  typedef struct packed {
    logic [OFF_W-1:0]  offset;
    logic [PROT_W-1:0] prot;
  } clhw_layer_t;

  typedef struct packed {
    logic [LOCKS-1:0]  req_reg;
    logic              rel_reg;
    logic [LOCKS-1:0]  pending;
    logic [LOCKS-1:0]  grant;
    logic              cur_valid;
    logic [LIDX_W-1:0] cur_idx;
    logic [LIDX_W-1:0] last_idx;
    logic              hidden;
  } clhw_arb_t;

  typedef struct packed {
    clhw_walk_t                   st;
    logic [1:0]                   lidx;
    clhw_layer_t [LAYERS-1:0]     layer;
    logic [PORT_W-1:0]            port_id;
    logic [HANDLE_W-1:0]          handle;
    logic [OFF_W-1:0]             fetch_off;
    logic [DATA_W-1:0]            key;
    logic [LAYERS-1:0]            match_start;
    logic [LAYERS-1:0]            match_reset;
    logic [LAYERS-1:0]            layer_done;
    logic [LAYERS-1:0][RES_W-1:0] result;
    logic [LAYERS-1:0][RES_W-1:0] status;
    logic                         start;
    logic                         abort;
    logic                         error;
    logic                         done_pend;
    logic                         all_done;
  } clhw_hw_t;

  typedef struct packed {
    clhw_arb_t arb;
    clhw_hw_t  walk;
  } clhw_state_t;

endpackage

// ---- hdl/clhw_top.sv ----
// Lock arbiter and layer-by-layer header walker of a packet classifier
`timescale 1ns/1ns

// What this block does
// - Posted lock requests are granted one at a time in round-robin order.
// - Hidden lock is set when a walk starts, cleared by resolution release.
// - Lock 0 is taken by a request write, freed by classification release.
// - Other locks are taken by request write, freed by global release write.
// - Lock 0 request queues when busy, else becomes current with its grant flag.
// - Lock I request queues when busy, else becomes current with grant flag I.
// - Classification release grants next queued request only if hidden lock is clear.
// - Global release and resolution release grant the next queued request only if no lock, hidden included, stays held.
// - Request and release registers clear on read; requester clears grant flags.
// - Layers 3 and 4 pass offset and protocol on; layers 3, 4, 7 record them.
// - Layer 2 stage hands supplied offset and protocol to layer 3.
// - A supported protocol identifier starts the matching protocol handler.
// - Unsupported protocol: abort, layer error, reset matchers, next protocol all ones.
// - Layer reset resets busy matchers; their result is 0xFF, status 0x00.
// - Layer 2 stage pulses the start indication for every new classification.
// - Handler fetches its header, derives next layer, triggers it, launches matcher.
// - Next layer is triggered only after the header fetch has completed.
// - A layer signals done once its matcher has finished.
// - Resolution done resets busy matchers, then pulses all matches done.
// - Layer 3 offset ignores its two least significant bits.
module clhw_top (
  // Clock and reset
  input  wire logic                                      CLK_I,
  input  wire logic                                      RESET_N_I,
  // Lock requests and releases
  input  wire logic [clhw_pkg::LOCKS-1:0]                REQ_WR_I,
  input  wire logic [clhw_pkg::LOCKS-1:0]                REQ_RD_I,
  input  wire logic                                      RELEASE_WR_I,
  input  wire logic                                      RELEASE_RD_I,
  input  wire logic [clhw_pkg::LOCKS-1:0]                GRANT_CLR_I,
  input  wire logic                                      CLASSIFY_RELEASE_I,
  input  wire logic                                      RESOLUTION_RELEASE_I,
  // Lock status
  output logic      [clhw_pkg::LOCKS-1:0]                REQ_REG_O,
  output logic                                           RELEASE_REG_O,
  output logic      [clhw_pkg::LOCKS-1:0]                GRANT_FLAG_O,
  output logic                                           CURRENT_VALID_O,
  output logic      [clhw_pkg::LIDX_W-1:0]               CURRENT_IDX_O,
  output logic                                           HIDDEN_LOCK_O,
  // Walk request
  input  wire logic                                      WALK_TRIGGER_I,
  input  wire logic [clhw_pkg::HANDLE_W-1:0]             PACKET_HANDLE_I,
  input  wire logic [clhw_pkg::OFF_W-1:0]                L3_OFFSET_I,
  input  wire logic [clhw_pkg::PORT_W-1:0]               INGRESS_PORT_ID_I,
  input  wire logic [clhw_pkg::PROT_W-1:0]               L2_NEXT_PROTOCOL_I,
  input  wire logic                                      RESOLUTION_DONE_I,
  // Walk results towards the result collector
  output logic                                           START_O,
  output logic                                           ABORT_O,
  output logic                                           LAYER_ERROR_O,
  output logic                                           ALL_MATCHES_DONE_O,
  output logic                                           WALK_BUSY_O,
  output logic      [clhw_pkg::PORT_W-1:0]               INGRESS_PORT_O,
  output clhw_pkg::clhw_layer_t [clhw_pkg::LAYERS-1:0]   LAYER_INFO_O,
  output logic      [clhw_pkg::LAYERS-1:0]               LAYER_DONE_O,
  output logic      [clhw_pkg::LAYERS-1:0][7:0]          LAYER_RESULT_O,
  output logic      [clhw_pkg::LAYERS-1:0][7:0]          LAYER_STATUS_O,
  // Packet fetch channel
  output logic                                           FETCH_REQ_O,
  output logic      [clhw_pkg::HANDLE_W-1:0]             FETCH_HANDLE_O,
  output logic      [clhw_pkg::OFF_W-1:0]                FETCH_OFFSET_O,
  input  wire logic                                      FETCH_ACK_I,
  input  wire logic [clhw_pkg::DATA_W-1:0]               FETCH_DATA_I,
  // Field matchers, one per layer
  output logic      [clhw_pkg::LAYERS-1:0]               MATCH_START_O,
  output logic      [clhw_pkg::LAYERS-1:0]               MATCH_RESET_O,
  output logic      [clhw_pkg::DATA_W-1:0]               MATCH_KEY_O,
  input  wire logic [clhw_pkg::LAYERS-1:0]               MATCH_DONE_I,
  input  wire logic [clhw_pkg::LAYERS-1:0][7:0]          MATCH_RESULT_I,
  input  wire logic [clhw_pkg::LAYERS-1:0][7:0]          MATCH_STATUS_I
);

  // ***********************************************************
  // Helpers
  // ***********************************************************
  // Returns {found, index}; the nearest pending index after last wins
  function automatic logic [clhw_pkg::LIDX_W:0] rr_pick(
    input logic [clhw_pkg::LOCKS-1:0]  p,
    input logic [clhw_pkg::LIDX_W-1:0] last
  );
    logic [clhw_pkg::LIDX_W:0]   res;
    logic [clhw_pkg::LIDX_W-1:0] j;
    res = '0;
    // Counting down leaves the nearest hit written last
    for (int i = clhw_pkg::LOCKS; i >= 1; i--) begin
      j = last + clhw_pkg::LIDX_W'(i);
      if (p[j]) begin
        res = {1'b1, j};
      end
    end
    return res;
  endfunction

  function automatic logic prot_known(
    input logic [1:0]                  lyr,
    input logic [clhw_pkg::PROT_W-1:0] pr
  );
    logic ok;
    case (lyr)
      clhw_pkg::L3_IDX: ok = (pr == clhw_pkg::L3_PROT_V4) || (pr == clhw_pkg::L3_PROT_V6);
      clhw_pkg::L4_IDX: ok = (pr == clhw_pkg::L4_PROT_TCP) || (pr == clhw_pkg::L4_PROT_UDP);
      clhw_pkg::L7_IDX: ok = (pr == clhw_pkg::L7_PROT_WEB) || (pr == clhw_pkg::L7_PROT_NAME);
      default:          ok = 1'b0;
    endcase
    return ok;
  endfunction

  // ***********************************************************
  // State
  // ***********************************************************
  clhw_pkg::clhw_state_t s_r;
  clhw_pkg::clhw_state_t s_nxt;

  always_comb begin
    logic [clhw_pkg::LIDX_W:0]    pick;
    logic                         busy;
    logic                         layer_rst;
    logic [clhw_pkg::HDR_LEN_W-1:0] hlen;

    pick      = '0;
    busy      = 1'b0;
    layer_rst = 1'b0;
    hlen      = '0;
    s_nxt     = s_r;
    s_nxt.walk.start       = 1'b0;
    s_nxt.walk.abort       = 1'b0;
    s_nxt.walk.match_reset = '0;

    // ---------------- Lock arbiter ----------------
    // clear on read, a new write wins
    s_nxt.arb.req_reg = (s_r.arb.req_reg & ~REQ_RD_I) | REQ_WR_I;
    s_nxt.arb.rel_reg = (s_r.arb.rel_reg & ~RELEASE_RD_I) | RELEASE_WR_I;
    s_nxt.arb.grant   = s_r.arb.grant & ~GRANT_CLR_I;
    // requests queue first, then are served if idle
    s_nxt.arb.pending = s_r.arb.pending | REQ_WR_I;
    if (CLASSIFY_RELEASE_I && s_r.arb.cur_valid && s_r.arb.cur_idx == '0) begin
      s_nxt.arb.cur_valid = 1'b0;
    end
    // global release frees a configuration lock
    if (RELEASE_WR_I && s_r.arb.cur_valid && s_r.arb.cur_idx != '0) begin
      s_nxt.arb.cur_valid = 1'b0;
    end
    // hidden lock, set wins over release
    if (RESOLUTION_RELEASE_I) begin
      s_nxt.arb.hidden = 1'b0;
    end
    if (WALK_TRIGGER_I && s_r.walk.st == clhw_pkg::W_IDLE) begin
      s_nxt.arb.hidden = 1'b1;
    end
    // serve next only when nothing, hidden included, holds
    busy = s_nxt.arb.cur_valid || s_nxt.arb.hidden;
    pick = rr_pick(s_nxt.arb.pending, s_r.arb.last_idx);
    if (!busy && pick[clhw_pkg::LIDX_W]) begin
      s_nxt.arb.cur_valid = 1'b1;
      s_nxt.arb.cur_idx   = pick[clhw_pkg::LIDX_W-1:0];
      s_nxt.arb.last_idx  = pick[clhw_pkg::LIDX_W-1:0];
      s_nxt.arb.pending[pick[clhw_pkg::LIDX_W-1:0]] = 1'b0;
      s_nxt.arb.grant[pick[clhw_pkg::LIDX_W-1:0]]   = 1'b1;
    end

    // ---------------- Matcher completion ----------------
    for (int l = 0; l < clhw_pkg::LAYERS; l++) begin
      // per-layer done once its matcher finishes
      if (s_r.walk.match_start[l] && MATCH_DONE_I[l]) begin
        s_nxt.walk.match_start[l] = 1'b0;
        s_nxt.walk.layer_done[l]  = 1'b1;
        s_nxt.walk.result[l]      = MATCH_RESULT_I[l];
        s_nxt.walk.status[l]      = MATCH_STATUS_I[l];
      end
    end

    // ---------------- Header walker ----------------
    case (s_r.walk.st)
      clhw_pkg::W_IDLE: begin
        if (WALK_TRIGGER_I) begin
          s_nxt.walk.start      = 1'b1;
          s_nxt.walk.error      = 1'b0;
          // A new walk drops stale done flags
          s_nxt.walk.layer_done = '0;
          s_nxt.walk.port_id    = INGRESS_PORT_ID_I;
          s_nxt.walk.handle     = PACKET_HANDLE_I;
          for (int l = 1; l < clhw_pkg::LAYERS; l++) begin
            s_nxt.walk.layer[l] = '{offset: '0, prot: clhw_pkg::PROT_UNKNOWN};
          end
          // layer 3 gets aligned offset and protocol
          s_nxt.walk.layer[0].offset = L3_OFFSET_I & clhw_pkg::ALIGN_MASK;
          s_nxt.walk.layer[0].prot   = L2_NEXT_PROTOCOL_I;
          s_nxt.walk.lidx            = clhw_pkg::L3_IDX;
          s_nxt.walk.st              = clhw_pkg::W_SELECT;
        end
      end
      clhw_pkg::W_SELECT: begin
        if (prot_known(s_r.walk.lidx, s_r.walk.layer[s_r.walk.lidx].prot)) begin
          s_nxt.walk.fetch_off = s_r.walk.layer[s_r.walk.lidx].offset;
          s_nxt.walk.st        = clhw_pkg::W_FETCH;
        end else begin
          // abort and spread the error onward
          s_nxt.walk.abort = 1'b1;
          s_nxt.walk.error = 1'b1;
          layer_rst        = 1'b1;
          if (s_r.walk.lidx != clhw_pkg::L7_IDX) begin
            s_nxt.walk.layer[s_r.walk.lidx + 2'h1].prot = clhw_pkg::PROT_UNKNOWN;
          end
          s_nxt.walk.st = clhw_pkg::W_IDLE;
        end
      end
      clhw_pkg::W_FETCH: begin
        // next layer only after the fetch returns
        if (FETCH_ACK_I) begin
          // launch matcher and derive next layer
          s_nxt.walk.key                         = FETCH_DATA_I;
          s_nxt.walk.match_start[s_r.walk.lidx]  = 1'b1;
          hlen = FETCH_DATA_I[clhw_pkg::HDR_LEN_LSB +: clhw_pkg::HDR_LEN_W];
          if (s_r.walk.lidx != clhw_pkg::L7_IDX) begin
            // forward offset and protocol to the next layer
            s_nxt.walk.layer[s_r.walk.lidx + 2'h1].offset =
              s_r.walk.fetch_off + {6'h00, hlen, 2'b00};
            s_nxt.walk.layer[s_r.walk.lidx + 2'h1].prot =
              FETCH_DATA_I[clhw_pkg::NXT_PROT_LSB +: clhw_pkg::PROT_W];
            s_nxt.walk.lidx = s_r.walk.lidx + 2'h1;
            s_nxt.walk.st   = clhw_pkg::W_SELECT;
          end else begin
            s_nxt.walk.st = clhw_pkg::W_IDLE;
          end
        end
      end
      default: begin
        s_nxt.walk.st = clhw_pkg::W_IDLE;
      end
    endcase

    // resolution done resets matchers, done follows a cycle later
    if (RESOLUTION_DONE_I) begin
      layer_rst = 1'b1;
    end
    s_nxt.walk.all_done  = s_r.walk.done_pend;
    s_nxt.walk.done_pend = RESOLUTION_DONE_I;

    // reset busy matchers, forcing no-match values
    if (layer_rst) begin
      for (int l = 0; l < clhw_pkg::LAYERS; l++) begin
        if (s_nxt.walk.match_start[l]) begin
          s_nxt.walk.match_reset[l] = 1'b1;
          s_nxt.walk.match_start[l] = 1'b0;
          s_nxt.walk.result[l]      = clhw_pkg::RESET_RESULT;
          s_nxt.walk.status[l]      = clhw_pkg::RESET_STATUS;
        end
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      s_r         <= '0;
      s_r.walk.st <= clhw_pkg::W_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ***********************************************************
  // Outputs
  // ***********************************************************
  assign REQ_REG_O          = s_r.arb.req_reg;
  assign RELEASE_REG_O      = s_r.arb.rel_reg;
  assign GRANT_FLAG_O       = s_r.arb.grant;
  assign CURRENT_VALID_O    = s_r.arb.cur_valid;
  assign CURRENT_IDX_O      = s_r.arb.cur_idx;
  assign HIDDEN_LOCK_O      = s_r.arb.hidden;
  assign START_O            = s_r.walk.start;
  assign ABORT_O            = s_r.walk.abort;
  assign LAYER_ERROR_O      = s_r.walk.error;
  assign ALL_MATCHES_DONE_O = s_r.walk.all_done;
  assign WALK_BUSY_O        = (s_r.walk.st != clhw_pkg::W_IDLE);
  assign INGRESS_PORT_O     = s_r.walk.port_id;
  assign LAYER_INFO_O       = s_r.walk.layer;
  assign LAYER_DONE_O       = s_r.walk.layer_done;
  assign LAYER_RESULT_O     = s_r.walk.result;
  assign LAYER_STATUS_O     = s_r.walk.status;
  assign FETCH_REQ_O        = (s_r.walk.st == clhw_pkg::W_FETCH);
  assign FETCH_HANDLE_O     = s_r.walk.handle;
  assign FETCH_OFFSET_O     = s_r.walk.fetch_off;
  assign MATCH_START_O      = s_r.walk.match_start;
  assign MATCH_RESET_O      = s_r.walk.match_reset;
  assign MATCH_KEY_O        = s_r.walk.key;

endmodule

// ---- verif/clhw_top_chk.sv ----
// Port assertions for the lock arbiter and header walker
`timescale 1ns/1ns
module clhw_top_chk (
  // Clock and reset
  input wire logic                                    CLK_I,
  input wire logic                                    RESET_N_I,
  // Lock side
  input wire logic [clhw_pkg::LOCKS-1:0]              REQ_WR_I,
  input wire logic                                    RELEASE_WR_I,
  input wire logic                                    CLASSIFY_RELEASE_I,
  input wire logic                                    RESOLUTION_RELEASE_I,
  input wire logic [clhw_pkg::LOCKS-1:0]              GRANT_FLAG_O,
  input wire logic                                    CURRENT_VALID_O,
  input wire logic [clhw_pkg::LIDX_W-1:0]             CURRENT_IDX_O,
  input wire logic                                    HIDDEN_LOCK_O,
  // Walker side
  input wire logic                                    WALK_TRIGGER_I,
  input wire logic                                    WALK_BUSY_O,
  input wire logic [clhw_pkg::OFF_W-1:0]              L3_OFFSET_I,
  input wire logic [clhw_pkg::PROT_W-1:0]             L2_NEXT_PROTOCOL_I,
  input wire clhw_pkg::clhw_layer_t [clhw_pkg::LAYERS-1:0] LAYER_INFO_O,
  input wire logic                                    START_O,
  input wire logic                                    ABORT_O,
  input wire logic                                    LAYER_ERROR_O,
  input wire logic                                    RESOLUTION_DONE_I,
  input wire logic                                    ALL_MATCHES_DONE_O,
  input wire logic                                    FETCH_REQ_O,
  input wire logic                                    FETCH_ACK_I,
  input wire logic [clhw_pkg::OFF_W-1:0]              FETCH_OFFSET_O,
  input wire logic [clhw_pkg::LAYERS-1:0]             MATCH_START_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);

  chk_grant_when_idle: assert property (
    ($onehot(REQ_WR_I) && !CURRENT_VALID_O && !HIDDEN_LOCK_O
    && !(WALK_TRIGGER_I && !WALK_BUSY_O)) |=> CURRENT_VALID_O
    && ((GRANT_FLAG_O & $past(REQ_WR_I)) != 4'h0)) else $error("idle request not granted");
  chk_current_kept: assert property ((CURRENT_VALID_O && !RESOLUTION_RELEASE_I
    && !((CURRENT_IDX_O == 2'h0) ? CLASSIFY_RELEASE_I : RELEASE_WR_I))
    |=> CURRENT_VALID_O && $stable(CURRENT_IDX_O)) else $error("current lock lost");
  chk_hidden_set: assert property ((WALK_TRIGGER_I && !WALK_BUSY_O)
    |=> START_O && HIDDEN_LOCK_O ##1 !START_O) else $error("walk start wrong");
  chk_hidden_hold: assert property (
    (HIDDEN_LOCK_O && !RESOLUTION_RELEASE_I) |=> HIDDEN_LOCK_O)
    else $error("hidden lock dropped early");
  chk_l3_record: assert property ((WALK_TRIGGER_I && !WALK_BUSY_O)
    |=> LAYER_INFO_O[0] ==
    {$past(L3_OFFSET_I) & clhw_pkg::ALIGN_MASK, $past(L2_NEXT_PROTOCOL_I)})
    else $error("layer 3 record wrong");
  chk_abort_error: assert property (ABORT_O |-> LAYER_ERROR_O ##1 !ABORT_O)
    else $error("abort without error");
  chk_all_done_lag: assert property (RESOLUTION_DONE_I |-> ##2 ALL_MATCHES_DONE_O)
    else $error("all done late");
  chk_all_done_cause: assert property (
    ALL_MATCHES_DONE_O |-> $past(RESOLUTION_DONE_I, 2)) else $error("all done without cause");
  chk_fetch_hold: assert property ((FETCH_REQ_O && !FETCH_ACK_I)
    |=> FETCH_REQ_O && $stable(FETCH_OFFSET_O)) else $error("fetch dropped");
  chk_match_after_fetch: assert property (
    ((MATCH_START_O & ~$past(MATCH_START_O)) != 3'h0) |-> $past(FETCH_ACK_I))
    else $error("matcher before fetch");
endmodule

bind clhw_top clhw_top_chk u_chk (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .REQ_WR_I(REQ_WR_I),
  .RELEASE_WR_I(RELEASE_WR_I), .CLASSIFY_RELEASE_I(CLASSIFY_RELEASE_I),
  .RESOLUTION_RELEASE_I(RESOLUTION_RELEASE_I), .GRANT_FLAG_O(GRANT_FLAG_O),
  .CURRENT_VALID_O(CURRENT_VALID_O), .CURRENT_IDX_O(CURRENT_IDX_O),
  .HIDDEN_LOCK_O(HIDDEN_LOCK_O), .WALK_TRIGGER_I(WALK_TRIGGER_I), .WALK_BUSY_O(WALK_BUSY_O),
  .L3_OFFSET_I(L3_OFFSET_I), .L2_NEXT_PROTOCOL_I(L2_NEXT_PROTOCOL_I),
  .LAYER_INFO_O(LAYER_INFO_O), .START_O(START_O), .ABORT_O(ABORT_O),
  .LAYER_ERROR_O(LAYER_ERROR_O), .RESOLUTION_DONE_I(RESOLUTION_DONE_I),
  .ALL_MATCHES_DONE_O(ALL_MATCHES_DONE_O), .FETCH_REQ_O(FETCH_REQ_O),
  .FETCH_ACK_I(FETCH_ACK_I), .FETCH_OFFSET_O(FETCH_OFFSET_O), .MATCH_START_O(MATCH_START_O));

// ---- verif/clhw_far_model.sv ----
// Far side model: packet fetch unit and one field matcher per layer
`timescale 1ns/1ns
module clhw_far_model (
  // Clock and behaviour
  input  wire logic                 clk_i,
  input  wire logic [3:0]           lat_i,
  input  wire logic [2:0][31:0]     words_i,
  // Fetch channel
  input  wire logic                 fetch_req_i,
  input  wire logic                 start_i,
  output logic                      fetch_ack_o,
  output logic      [31:0]          fetch_data_o,
  // Matchers
  input  wire logic [2:0]           match_start_i,
  output logic      [2:0]           match_done_o,
  output logic      [2:0][7:0]      match_result_o,
  output logic      [2:0][7:0]      match_status_o
);
  logic [3:0]      wait_q = 4'h0;
  logic [1:0]      word_q = 2'h0;
  logic [2:0][3:0] busy_q = '0;

  initial begin
    fetch_ack_o = 1'b0;
    fetch_data_o = 32'h0000_0000;
    match_done_o = 3'h0;
    match_result_o = '0;
    match_status_o = '0;
  end

  always @(posedge clk_i) begin
    fetch_ack_o <= 1'b0;
    // Data toggles outside ack so a late sample is caught
    fetch_data_o <= ~fetch_data_o;
    match_done_o <= 3'h0;
    if (start_i) begin
      word_q <= 2'h0;
    end
    if (fetch_req_i && !fetch_ack_o) begin
      wait_q <= wait_q + 4'h1;
      if (wait_q >= lat_i) begin
        fetch_ack_o <= 1'b1;
        fetch_data_o <= words_i[word_q];
        word_q <= word_q + 2'h1;
        wait_q <= 4'h0;
      end
    end
    for (int l = 0; l < 3; l++) begin
      busy_q[l] <= match_start_i[l] ? busy_q[l] + 4'h1 : 4'h0;
      match_result_o[l] <= ~match_result_o[l];
      match_status_o[l] <= ~match_status_o[l];
      if (match_start_i[l] && busy_q[l] == lat_i) begin
        match_done_o[l] <= 1'b1;
        match_result_o[l] <= 8'h40 + 8'(l);
        match_status_o[l] <= 8'h01;
      end
    end
  end
endmodule

// ---- verif/clhw_top_test.sv ----
// Self-checking bench for the lock arbiter and header walker
`timescale 1ns/1ns
module clhw_top_test;
  logic                         clk, rst_n, rel_wr, rel_rd, cls_rel, res_rel, rel_reg, cur_valid;
  logic                         hidden, trig, res_done, start, abort, lerr, all_done, busy;
  logic                         fetch_req, fetch_ack;
  logic [3:0]                   req_wr, req_rd, grant_clr, req_reg, grant, lat;
  logic [1:0]                   cur_idx;
  logic [31:0]                  handle, fetch_handle, fetch_data, key;
  logic [15:0]                  l3_off, l2_prot, fetch_off;
  logic [7:0]                   port, port_o;
  logic [2:0]                   ldone, mstart, mreset, mdone;
  logic [2:0][7:0]              lres, lstat, mres, mstat;
  logic [2:0][31:0]             words;
  clhw_pkg::clhw_layer_t [2:0]  info;
  int                           mismatches, checked;

  clhw_top u_dut (.CLK_I(clk), .RESET_N_I(rst_n), .REQ_WR_I(req_wr), .REQ_RD_I(req_rd),
    .RELEASE_WR_I(rel_wr), .RELEASE_RD_I(rel_rd), .GRANT_CLR_I(grant_clr),
    .CLASSIFY_RELEASE_I(cls_rel), .RESOLUTION_RELEASE_I(res_rel), .REQ_REG_O(req_reg),
    .RELEASE_REG_O(rel_reg), .GRANT_FLAG_O(grant), .CURRENT_VALID_O(cur_valid),
    .CURRENT_IDX_O(cur_idx), .HIDDEN_LOCK_O(hidden), .WALK_TRIGGER_I(trig),
    .PACKET_HANDLE_I(handle), .L3_OFFSET_I(l3_off), .INGRESS_PORT_ID_I(port),
    .L2_NEXT_PROTOCOL_I(l2_prot), .RESOLUTION_DONE_I(res_done), .START_O(start),
    .ABORT_O(abort), .LAYER_ERROR_O(lerr), .ALL_MATCHES_DONE_O(all_done), .WALK_BUSY_O(busy),
    .INGRESS_PORT_O(port_o), .LAYER_INFO_O(info), .LAYER_DONE_O(ldone), .LAYER_RESULT_O(lres),
    .LAYER_STATUS_O(lstat), .FETCH_REQ_O(fetch_req), .FETCH_HANDLE_O(fetch_handle),
    .FETCH_OFFSET_O(fetch_off), .FETCH_ACK_I(fetch_ack), .FETCH_DATA_I(fetch_data),
    .MATCH_START_O(mstart), .MATCH_RESET_O(mreset), .MATCH_KEY_O(key), .MATCH_DONE_I(mdone),
    .MATCH_RESULT_I(mres), .MATCH_STATUS_I(mstat));

  clhw_far_model u_far (.clk_i(clk), .lat_i(lat), .words_i(words), .fetch_req_i(fetch_req),
    .start_i(start), .fetch_ack_o(fetch_ack), .fetch_data_o(fetch_data),
    .match_start_i(mstart), .match_done_o(mdone), .match_result_o(mres),
    .match_status_o(mstat));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One cycle of lock side strobes; misc is {resolution, classify, release read, release write}
  task automatic strobe(input logic [3:0] wr, input logic [3:0] clr, input logic [3:0] rd,
                        input logic [3:0] misc);
    {req_wr, grant_clr, req_rd} = {wr, clr, rd};
    {res_rel, cls_rel, rel_rd, rel_wr} = misc;
    cyc(1);
    {req_wr, grant_clr, req_rd, res_rel, cls_rel, rel_rd, rel_wr} = '0;
    cyc(1);
  endtask

  task automatic walk(input logic [15:0] off, input logic [15:0] prot, input logic [7:0] id);
    {l3_off, l2_prot, port, handle, trig} = {off, prot, id, 32'h0000_1234, 1'b1};
    cyc(1);
    trig = 1'b0;
  endtask

  // Bounded wait: 0 walker idle, 1 all layers done, 2 abort seen
  task automatic wait_for(input int sel);
    int n;
    n = 0;
    while (n < 200 && !(sel == 0 ? busy === 1'b0 :
           sel == 1 ? ldone === 3'h7 : abort === 1'b1)) begin
      cyc(1);
      n++;
    end
    if (n == 200) mismatches++;
  endtask

  task automatic end_sim;
    if (mismatches == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    #40000;
    mismatches++;
    end_sim;
  end

  initial begin
    {rst_n, req_wr, req_rd, grant_clr, rel_wr, rel_rd, cls_rel, res_rel, trig, res_done} = '0;
    {handle, l3_off, l2_prot, port} = '0;
    lat = 4'h2;
    words = {32'h0000_0000, 32'h0002_0050, 32'h0005_0006};
    cyc(10);
    rst_n = 1'b1;
    check({req_reg, grant, cur_valid, hidden, start}, 11'h000);
    strobe(4'h4, 4'h0, 4'h0, 4'h0);
    check({grant, cur_valid, cur_idx, req_reg}, {4'h4, 1'b1, 2'h2, 4'h4});
    strobe(4'hA, 4'h0, 4'h0, 4'h0);
    check({grant, cur_idx}, {4'h4, 2'h2});
    strobe(4'h0, 4'h4, 4'h4, 4'h0);
    check({grant, req_reg}, {4'h0, 4'hA});
    strobe(4'h0, 4'h0, 4'h0, 4'h1);
    check({grant, cur_idx, rel_reg}, {4'h8, 2'h3, 1'b1});
    strobe(4'h0, 4'h8, 4'h0, 4'h2);
    check({grant, rel_reg}, {4'h0, 1'b0});
    strobe(4'h0, 4'h0, 4'h0, 4'h1);
    check({grant, cur_idx}, {4'h2, 2'h1});
    strobe(4'h0, 4'h2, 4'h0, 4'h1);
    check({grant, cur_valid}, 5'h00);
    strobe(4'h1, 4'h0, 4'h0, 4'h0);
    check({grant, cur_valid, cur_idx}, {4'h1, 1'b1, 2'h0});
    strobe(4'h2, 4'h1, 4'h0, 4'h1);
    check({grant, cur_valid, cur_idx}, {4'h0, 1'b1, 2'h0});
    strobe(4'h0, 4'h0, 4'h0, 4'h4);
    check({grant, cur_idx}, {4'h2, 2'h1});
    strobe(4'h0, 4'h2, 4'h0, 4'h1);
    check(cur_valid, 1'b0);
    walk(16'h0013, clhw_pkg::L3_PROT_V4, 8'hA5);
    check({start, hidden, info[0], port_o}, {2'h3, 16'h0010, 16'h0800, 8'hA5});
    wait_for(0);
    check({info[1], info[2]}, {32'h0024_0006, 32'h002C_0050});
    wait_for(1);
    check({lres, lstat}, 48'h4241_4001_0101);
    strobe(4'h2, 4'h0, 4'h0, 4'h0);
    check(grant, 4'h0);
    strobe(4'h0, 4'h0, 4'h0, 4'h4);
    check(grant, 4'h0);
    strobe(4'h0, 4'h0, 4'h0, 4'h8);
    check({grant, hidden}, {4'h2, 1'b0});
    strobe(4'h0, 4'h2, 4'h0, 4'h1);
    res_done = 1'b1;
    cyc(1);
    res_done = 1'b0;
    check(all_done, 1'b0);
    cyc(1);
    check(all_done, 1'b1);
    lat = 4'h8;
    words[0] = 32'h0005_0099;
    walk(16'h0040, clhw_pkg::L3_PROT_V6, 8'h3C);
    wait_for(2);
    check({lerr, mreset, mstart, ldone, lres[0], lstat[0], info[2].prot},
          {1'b1, 3'h1, 3'h0, 3'h0, 8'hFF, 8'h00, 16'hFFFF});
    check(info[1], 32'h0054_0099);
    check({fetch_handle, key}, {32'h0000_1234, 32'h0005_0099});
    end_sim;
  end
endmodule
